// File: cfd_pkg.sv
// package: shared constants and types for the channel fault diagnosis block
package cfd_pkg;

   // number of channels
   localparam int CHANNELS = 8;

   // channel mode codes
   localparam logic [1:0] MODE_STANDBY = 2'h0;
   localparam logic [1:0] MODE_INPUT   = 2'h1;
   localparam logic [1:0] MODE_ON      = 2'h2;
   localparam logic [1:0] MODE_OFF     = 2'h3;

   // clock rate
   localparam int CLK_PERIOD_NS = 10;

   // overload shut-off delay window, microseconds
   localparam int OVL_DELAY_MIN_US = 3;
   localparam int OVL_DELAY_MAX_US = 50;
   // open-load qualification delay window, microseconds
   localparam int OL_DELAY_MIN_US  = 30;
   localparam int OL_DELAY_MAX_US  = 200;
   // reset and limp-home least low time, microseconds
   localparam int RST_LOW_MIN_US   = 50;

   // cycle counts; least times round up, longest round down
   localparam int OVL_DELAY_MIN_CYC = (OVL_DELAY_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OVL_DELAY_MAX_CYC = (OVL_DELAY_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int OL_DELAY_MIN_CYC  = (OL_DELAY_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OL_DELAY_MAX_CYC  = (OL_DELAY_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int RST_LOW_MIN_CYC   = (RST_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // counter width that holds every delay above
   localparam int CNT_W = 16;

   // reset value of the mode word: every channel in off mode
   localparam logic [15:0] MODE_RESET = 16'hFFFF;

   // sense inputs of one channel
   typedef struct packed {
      logic overload;   // overload comparator
      logic overtemp;   // over-temperature sensor
      logic open_load;  // output-voltage open-load comparator
   } cfd_sense_t;

   // state reported for one channel
   typedef struct packed {
      logic drive;               // power stage gate
      logic diag_current;        // pull-down diagnosis current enable
      logic protect_fault_flag;  // latched overload / overtemp
      logic open_load_flag;      // latched open load
   } cfd_status_t;

   // delay counter states
   typedef enum logic [1:0] {
      CFD_IDLE    = 2'b00,
      CFD_COUNT   = 2'b01,
      CFD_EXPIRED = 2'b10
   } cfd_qual_t;

endpackage : cfd_pkg

// File: cfd_qual.sv
// module: qualification counter that reports a condition held for a set time
`timescale 1ns/1ps
module cfd_qual #(
   parameter int DELAY = 100     // cycles the condition must hold
) (
   input  wire logic CLK,        // clock
   input  wire logic RST_N,      // synchronous reset, active low
   input  wire logic CE,         // clock enable
   input  wire logic cond,       // condition to qualify
   output logic      expired     // condition held for DELAY cycles
);

   cfd_pkg::cfd_qual_t          state;
   cfd_pkg::cfd_qual_t          next_state;
   logic [cfd_pkg::CNT_W-1:0]   cnt;
   logic [cfd_pkg::CNT_W-1:0]   next_cnt;

   localparam logic [cfd_pkg::CNT_W-1:0] LAST = cfd_pkg::CNT_W'(DELAY - 1);

   // next state: any drop of the condition restarts the count
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      unique case (state)
         cfd_pkg::CFD_IDLE: begin
            next_cnt = '0;
            if (cond) begin
               next_state = cfd_pkg::CFD_COUNT;
               next_cnt   = cfd_pkg::CNT_W'(1);
            end
         end
         cfd_pkg::CFD_COUNT: begin
            if (!cond) begin
               next_state = cfd_pkg::CFD_IDLE;
               next_cnt   = '0;
            end else if (cnt >= LAST) begin
               next_state = cfd_pkg::CFD_EXPIRED;
            end else begin
               next_cnt = cnt + cfd_pkg::CNT_W'(1);
            end
         end
         cfd_pkg::CFD_EXPIRED: begin
            if (!cond) begin
               next_state = cfd_pkg::CFD_IDLE;
               next_cnt   = '0;
            end
         end
         default: begin
            next_state = cfd_pkg::CFD_IDLE;
            next_cnt   = '0;
         end
      endcase
   end

   // register state
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state <= cfd_pkg::CFD_IDLE;
         cnt   <= '0;
      end else if (CE) begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   assign expired = (state == cfd_pkg::CFD_EXPIRED);

endmodule : cfd_qual

// File: cfd_top.sv
// module: per-channel protection and diagnosis for eight low-side switches
// Notes on behaviour
// - overload held for the shut-off delay turns channel off, sets fault flag
// - after protective shut-off the channel stays off until its fault flag clears
// - each channel's over-temperature sets its protection fault flag
// - over-temperature switches an active channel off; flag set regardless
// - both flags latch; only standby mode clears them
// - off channel with open-load comparator set latches open-load flag after delay
// - a switched-on channel does no open-load diagnosis
// - standby disables open-load diagnosis; off mode keeps it active
// - after power-on reset every channel starts idle: modes off, flags clear
// - an undriven direct-drive input reads low, keeping input-mode channels off
// - mode codes: 00 standby, 01 follow input, 10 on, 11 off with diagnosis
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module cfd_top #(
   parameter int CHANNELS = cfd_pkg::CHANNELS,           // channel count
   parameter int OVL_CYC  = cfd_pkg::OVL_DELAY_MAX_CYC,  // overload shut-off cycles
   parameter int OL_CYC   = cfd_pkg::OL_DELAY_MAX_CYC,   // open-load delay cycles
   parameter int LHI_CYC  = cfd_pkg::RST_LOW_MIN_CYC     // limp-home qualify cycles
) (
   input  wire logic                    CLK,       // 100 MHz clock
   input  wire logic                    RST_N,     // synchronous reset, active low
   input  wire logic                    CE,        // clock enable, freezes all state
   input  wire logic [3:0]              ADDR,      // register address
   input  wire logic [15:0]             WDATA,     // write data
   input  wire logic                    WR,        // write strobe
   input  wire logic                    RD,        // read strobe
   output logic      [15:0]             RDATA,     // read data, cycle after RD
   input  wire logic [CHANNELS-1:0]     DIRECT_DRIVE_INPUT, // direct-drive pins
   input  wire logic                    LIMP_HOME_INPUT_N,  // limp-home pin, active low
   input  wire cfd_pkg::cfd_sense_t [CHANNELS-1:0] SENSE,   // stage comparators
   output logic      [CHANNELS-1:0]     DRIVE,     // power stage gate per channel
   output logic      [CHANNELS-1:0]     DIAG_CURRENT, // diagnosis current enable
   output logic      [CHANNELS-1:0]     PROTECT_FAULT_FLAG, // latched fault flags
   output logic      [CHANNELS-1:0]     OPEN_LOAD_FLAG,     // latched open-load flags
   output logic                         LIMP_HOME  // limp-home active
);

   // register addresses
   // only the mode word takes writes; other addresses ignore them
   localparam logic [3:0] ADDR_MODE   = 4'h0;
   localparam logic [3:0] ADDR_DIAG   = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;

   // decode a channel's mode into drive intent
   function automatic logic mode_on(input logic [1:0] m, input logic pin);
      unique case (m)
         cfd_pkg::MODE_INPUT: mode_on = pin;
         cfd_pkg::MODE_ON:    mode_on = 1'b1;
         default:             mode_on = 1'b0;
      endcase
   endfunction : mode_on

   // standby decode, shared by the flag clear and the open-load gate
   function automatic logic is_standby(input logic [1:0] m);
      is_standby = (m == cfd_pkg::MODE_STANDBY);
   endfunction : is_standby

   // modes that allow the pull-down diagnosis current while the gate is off
   function automatic logic diag_allowed(input logic [1:0] m);
      diag_allowed = (m == cfd_pkg::MODE_OFF) || (m == cfd_pkg::MODE_INPUT);
   endfunction : diag_allowed

   logic [2*CHANNELS-1:0]   mode;          // mode word, two bits a channel
   logic [2*CHANNELS-1:0]   next_mode;
   logic [15:0]             next_rdata;

   // direct-drive pin synchroniser and filtered level
   logic [CHANNELS-1:0]     din_s1;        // first stage, may be metastable
   logic [CHANNELS-1:0]     din_s2;
   logic [CHANNELS-1:0]     din_s3;
   logic [CHANNELS-1:0]     din;           // filtered pin level
   logic [CHANNELS-1:0]     next_din;
   // overload comparator synchroniser
   logic [CHANNELS-1:0]     ovl_s1;
   logic [CHANNELS-1:0]     ovl_s2;
   logic [CHANNELS-1:0]     ovl_s3;
   logic [CHANNELS-1:0]     ovl;
   logic [CHANNELS-1:0]     next_ovl;
   // over-temperature sensor synchroniser
   logic [CHANNELS-1:0]     otp_s1;
   logic [CHANNELS-1:0]     otp_s2;
   logic [CHANNELS-1:0]     otp_s3;
   logic [CHANNELS-1:0]     otp;
   logic [CHANNELS-1:0]     next_otp;
   // open-load comparator synchroniser
   logic [CHANNELS-1:0]     opl_s1;
   logic [CHANNELS-1:0]     opl_s2;
   logic [CHANNELS-1:0]     opl_s3;
   logic [CHANNELS-1:0]     opl;
   logic [CHANNELS-1:0]     next_opl;
   // limp-home pin synchroniser, idles high
   logic                    lhi_s1;
   logic                    lhi_s2;
   logic                    lhi_s3;
   logic                    limp_home_input;
   logic                    next_lhi;

   // synchronise every pin: a change counts once stages two and three agree
   // a one-cycle glitch never makes stages two and three agree, so it is dropped
   // the single limp-home pin filters the same way
   always_comb begin
      next_din = din;
      next_ovl = ovl;
      next_otp = otp;
      next_opl = opl;
      next_lhi = limp_home_input;
      for (int i = 0; i < CHANNELS; i++) begin
         if (din_s2[i] == din_s3[i]) next_din[i] = din_s3[i];
         if (ovl_s2[i] == ovl_s3[i]) next_ovl[i] = ovl_s3[i];
         if (otp_s2[i] == otp_s3[i]) next_otp[i] = otp_s3[i];
         if (opl_s2[i] == opl_s3[i]) next_opl[i] = opl_s3[i];
      end
      if (lhi_s2 == lhi_s3) next_lhi = lhi_s3;
   end

   // shift pins through the stages; reset loads the idle pin levels
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         {din_s1, din_s2, din_s3, din} <= '0;
         {ovl_s1, ovl_s2, ovl_s3, ovl} <= '0;
         {otp_s1, otp_s2, otp_s3, otp} <= '0;
         {opl_s1, opl_s2, opl_s3, opl} <= '0;
         {lhi_s1, lhi_s2, lhi_s3, limp_home_input} <= 4'hF;
      end else if (CE) begin
         din_s1 <= DIRECT_DRIVE_INPUT;
         din_s2 <= din_s1;
         din_s3 <= din_s2;
         din    <= next_din;
         for (int i = 0; i < CHANNELS; i++) begin
            ovl_s1[i] <= SENSE[i].overload;
            otp_s1[i] <= SENSE[i].overtemp;
            opl_s1[i] <= SENSE[i].open_load;
         end
         ovl_s2 <= ovl_s1;
         ovl_s3 <= ovl_s2;
         ovl    <= next_ovl;
         otp_s2 <= otp_s1;
         otp_s3 <= otp_s2;
         otp    <= next_otp;
         opl_s2 <= opl_s1;
         opl_s3 <= opl_s2;
         opl    <= next_opl;
         lhi_s1 <= LIMP_HOME_INPUT_N;
         lhi_s2 <= lhi_s1;
         lhi_s3 <= lhi_s2;
         limp_home_input    <= next_lhi;
      end
   end

   // limp-home counts only after the pin stays low for the least time
   // a short low pulse restarts the count and never reaches the channels
   // the pin idles high, so reset leaves limp-home inactive
   logic lhi_active;
   cfd_qual #(.DELAY(LHI_CYC)) u_lhi_qual (
      .CLK     (CLK),
      .RST_N   (RST_N),
      .CE      (CE),
      .cond    (!limp_home_input),
      .expired (lhi_active)
   );

   // per-channel protection and diagnosis
   logic [CHANNELS-1:0] want_on;    // drive asked for by mode or limp-home
   logic [CHANNELS-1:0] ovl_exp;    // overload held for the shut-off delay
   logic [CHANNELS-1:0] ol_exp;     // open load held for the qualification delay
   logic [CHANNELS-1:0] ol_cond;    // open-load diagnosis condition
   // latched flags, gate and diagnosis current
   logic [CHANNELS-1:0] pff;
   logic [CHANNELS-1:0] olf;
   logic [CHANNELS-1:0] drv;
   logic [CHANNELS-1:0] dcur;
   logic [CHANNELS-1:0] next_pff;
   logic [CHANNELS-1:0] next_olf;
   logic [CHANNELS-1:0] next_drv;
   logic [CHANNELS-1:0] next_dcur;

   // one pair of qualification counters per channel
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         // limp-home forces direct drive from the pin
         assign want_on[g] = lhi_active ? din[g] : mode_on(mode[2*g+:2], din[g]);
         // open-load checked only off and not standby
         assign ol_cond[g] = opl[g] && !drv[g]
                             && !is_standby(mode[2*g+:2]);

         // overload only counts while the gate conducts
         cfd_qual #(.DELAY(OVL_CYC)) u_ovl (
            .CLK     (CLK),
            .RST_N   (RST_N),
            .CE      (CE),
            .cond    (ovl[g] && drv[g]),
            .expired (ovl_exp[g])
         );

         // open-load qualification, restarted by any drop of the condition
         cfd_qual #(.DELAY(OL_CYC)) u_ol (
            .CLK     (CLK),
            .RST_N   (RST_N),
            .CE      (CE),
            .cond    (ol_cond[g]),
            .expired (ol_exp[g])
         );
      end
   endgenerate

   // flag latching and drive gating
   // a set in the same cycle as a standby clear wins, so no event is lost
   // the gate reads next_pff so a shut-off lands in the cycle the fault is seen
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         next_pff[i] = pff[i];
         next_olf[i] = olf[i];
         if (is_standby(mode[2*i+:2])) begin
            next_pff[i] = 1'b0;
            next_olf[i] = 1'b0;
         end
         if (ovl_exp[i]) next_pff[i] = 1'b1;
         if (otp[i]) next_pff[i] = 1'b1;
         if (ol_exp[i]) next_olf[i] = 1'b1;
         // shut-off and hold off while fault flag stands
         next_drv[i] = want_on[i] && !next_pff[i] && !pff[i];
         // diagnosis current only while the gate is off
         next_dcur[i] = diag_allowed(mode[2*i+:2]) && !next_drv[i];
      end
   end

   // register flags, gate and diagnosis current
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         pff  <= '0;
         olf  <= '0;
         drv  <= '0;
         dcur <= '0;
      end else if (CE) begin
         pff  <= next_pff;
         olf  <= next_olf;
         drv  <= next_drv;
         dcur <= next_dcur;
      end
   end

   // register bus: mode write, flag and state read
   // unmapped addresses read as zero; read data fall back to zero after a read
   // a write and a read in the same cycle cannot occur on this bus
   always_comb begin
      next_mode  = mode;
      next_rdata = '0;
      if (WR && ADDR == ADDR_MODE) next_mode = WDATA[2*CHANNELS-1:0];
      if (RD) begin
         unique case (ADDR)
            ADDR_MODE: next_rdata = 16'(mode);
            ADDR_DIAG: begin
               // fault in even bits, open load in odd bits
               for (int i = 0; i < CHANNELS; i++) begin
                  next_rdata[2*i]   = pff[i];
                  next_rdata[2*i+1] = olf[i];
               end
            end
            ADDR_STATUS: next_rdata = {7'h00, lhi_active, drv};
            default:     next_rdata = '0;
         endcase
      end
   end

   // mode word and read data; reset leaves every channel in off mode
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         mode  <= cfd_pkg::MODE_RESET[2*CHANNELS-1:0];
         RDATA <= '0;
      end else if (CE) begin
         mode  <= next_mode;
         RDATA <= next_rdata;
      end
   end

   // outputs straight from flip-flops
   // one cycle of latency on every output keeps the pins glitch free
   // limp-home status follows its qualifier with the same latency
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         DRIVE              <= '0;
         DIAG_CURRENT       <= '0;
         PROTECT_FAULT_FLAG <= '0;
         OPEN_LOAD_FLAG     <= '0;
         LIMP_HOME          <= 1'b0;
      end else if (CE) begin
         DRIVE              <= drv;
         DIAG_CURRENT       <= dcur;
         PROTECT_FAULT_FLAG <= pff;
         OPEN_LOAD_FLAG     <= olf;
         LIMP_HOME          <= lhi_active;
      end
   end

endmodule : cfd_top

// File: cfd_checker.sv
// checker: protection and diagnosis timing at the block's ports
`timescale 1ns/1ps
module cfd_checker #(
   parameter int CHANNELS = 8,  // channel count
   parameter int OVL_CYC  = 8,  // overload cycles
   parameter int OL_CYC   = 8   // open-load cycles
) (
   input wire logic                               CLK,                // clock
   input wire logic                               RST_N,              // reset, active low
   input wire logic                               CE,                 // clock enable
   input wire logic [3:0]                         ADDR,               // address
   input wire logic [15:0]                        WDATA,              // write data
   input wire logic                               WR,                 // write strobe
   input wire logic                               RD,                 // read strobe
   input wire logic [15:0]                        RDATA,              // read data
   input wire cfd_pkg::cfd_sense_t [CHANNELS-1:0] SENSE,              // comparators
   input wire logic [CHANNELS-1:0]                DRIVE,              // gates
   input wire logic [CHANNELS-1:0]                PROTECT_FAULT_FLAG, // fault flags
   input wire logic [CHANNELS-1:0]                OPEN_LOAD_FLAG,     // open-load flags
   input wire logic                               LIMP_HOME           // limp-home
);
   logic [15:0]         mode, next_mode, ovl_run, next_ovl_run, ol_run, next_ol_run;
   logic [CHANNELS-1:0] sb;
   logic                rst_seen;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // shadow mode word and run lengths of channel 0 conditions
   always_comb begin
      next_mode = (CE && WR && ADDR == 4'h0) ? WDATA : mode;
      next_ovl_run = (SENSE[0].overload && DRIVE[0]) ? ovl_run + 16'h1 : 16'h0;
      next_ol_run = (SENSE[0].open_load && !DRIVE[0]) ? ol_run + 16'h1 : 16'h0;
      for (int i = 0; i < CHANNELS; i++) sb[i] = (mode[2*i+:2] == 2'h0);
   end
   // register the helpers
   always_ff @(posedge CLK) begin
      rst_seen <= !RST_N;
      mode <= RST_N ? next_mode : 16'hFFFF;
      ovl_run <= RST_N ? next_ovl_run : 16'h0;
      ol_run <= RST_N ? next_ol_run : 16'h0;
   end
   property p_fault_off; (PROTECT_FAULT_FLAG & $past(PROTECT_FAULT_FLAG) & DRIVE) == '0;
   endproperty
   a_fault_off: assert property (p_fault_off)
      else $error("faulted channel still driven");
   property p_flag_hold;
      ((($past(PROTECT_FAULT_FLAG) & ~PROTECT_FAULT_FLAG) | ($past(OPEN_LOAD_FLAG)
      & ~OPEN_LOAD_FLAG)) & ~(sb | $past(sb) | $past(sb, 2))) == '0;
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("flag cleared outside standby");
   property p_otemp; (SENSE[0].overtemp && CE) [*8] |=> PROTECT_FAULT_FLAG[0] && !DRIVE[0];
   endproperty
   a_otemp: assert property (p_otemp)
      else $error("over-temperature not acted on");
   property p_ovl_max; ovl_run <= OVL_CYC + 10; endproperty
   a_ovl_max: assert property (p_ovl_max)
      else $error("overload not shut off in time");
   property p_ol_min; $rose(OPEN_LOAD_FLAG[0]) |-> ol_run >= OL_CYC; endproperty
   a_ol_min: assert property (p_ol_min)
      else $error("open-load flag set too early");
   property p_ol_on;
      (~$past(OPEN_LOAD_FLAG) & OPEN_LOAD_FLAG & DRIVE & $past(DRIVE) & $past(DRIVE, 2)) == '0;
   endproperty
   a_ol_on: assert property (p_ol_on)
      else $error("open-load flag set while driven");
   property p_ol_sb;
      (~$past(OPEN_LOAD_FLAG) & OPEN_LOAD_FLAG & $past(sb) & $past(sb, 2) & $past(sb, 3)) == '0;
   endproperty
   a_ol_sb: assert property (p_ol_sb)
      else $error("open-load flag set in standby");
   property p_reset; rst_seen |-> (DRIVE | PROTECT_FAULT_FLAG | OPEN_LOAD_FLAG) == '0; endproperty
   a_reset: assert property (p_reset)
      else $error("outputs not idle after reset");
   c_fault: cover property ($rose(PROTECT_FAULT_FLAG[0]));
   c_open: cover property ($rose(OPEN_LOAD_FLAG[0]));
   c_limp: cover property ($rose(LIMP_HOME));
endmodule : cfd_checker

// File: cfd_stage.sv
// partner: power stage comparators driven by commanded load faults
`timescale 1ns/1ps
module cfd_stage (
   input  wire logic [7:0]           drive,   // gates from the block
   input  wire logic [7:0]           short_m, // load shorted
   input  wire logic [7:0]           open_m,  // load missing
   input  wire logic [7:0]           hot_m,   // junction too hot
   output cfd_pkg::cfd_sense_t [7:0] sense    // comparator outputs
);
   // overload flows only through a conducting gate; open and heat show always
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         sense[i].overload = drive[i] & short_m[i];
         sense[i].overtemp = hot_m[i];
         sense[i].open_load = open_m[i];
      end
   end
endmodule : cfd_stage

// File: test_channel_fault_diagnosis.sv
// testbench: modes, protection, open-load diagnosis and limp-home
`timescale 1ns/1ps
module test_channel_fault_diagnosis;
   localparam int OVL = 8;
   localparam int OL  = 12;
   localparam int LIMP_HOME_INPUT = 8;
   typedef struct packed { logic [15:0] mode; logic [7:0] din, drv, diag; } cfd_row_t;
   logic                      CLK, RST_N, WR, RD, lhi_n, limp, ce;
   logic [3:0]                ADDR;
   logic [15:0]               WDATA, RDATA;
   logic [7:0]                din, drive, diag, pf, ol, short_m, open_m, hot_m;
   cfd_pkg::cfd_sense_t [7:0] sense;
   int                        errors, compares, cycles;
   cfd_row_t rows [5] = '{'{16'hAAAA, 8'h00, 8'hFF, 8'h00}, '{16'h5555, 8'hA5, 8'hA5, 8'h5A},
      '{16'hFFFF, 8'h00, 8'h00, 8'hFF}, '{16'h0000, 8'h00, 8'h00, 8'h00},
      '{16'h1234, 8'hFF, 8'h52, 8'h04}};
   cfd_top #(.OVL_CYC(OVL), .OL_CYC(OL), .LHI_CYC(LIMP_HOME_INPUT)) dut_u (.CLK(CLK), .RST_N(RST_N),
      .CE(ce), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .DIRECT_DRIVE_INPUT(din), .LIMP_HOME_INPUT_N(lhi_n), .SENSE(sense), .DRIVE(drive),
      .DIAG_CURRENT(diag), .PROTECT_FAULT_FLAG(pf), .OPEN_LOAD_FLAG(ol), .LIMP_HOME(limp));
   cfd_stage stage_u (.drive(drive), .short_m(short_m), .open_m(open_m), .hot_m(hot_m),
      .sense(sense));
   // clock and hang guard
   initial CLK = 1'b0;
   always #5 CLK = ~CLK;
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         give_verdict();
      end
   end
   task give_verdict;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : tick
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, exp);
   endtask : rd
   // main sequence
   initial begin
      {RST_N, WR, RD, ADDR, WDATA, din, short_m, open_m, hot_m} = '0;
      {lhi_n, ce} = 2'b11;
      {errors, compares, cycles} = '0;
      repeat (4) @(posedge CLK);
      RST_N <= 1'b1;
      #1;
      chk({drive, pf}, 16'h0000);
      foreach (rows[i]) begin
         wr(4'h0, rows[i].mode);
         din <= rows[i].din;
         tick(8);
         chk({8'h00, drive}, {8'h00, rows[i].drv});
         chk({8'h00, diag}, {8'h00, rows[i].diag});
      end
      wr(4'h0, 16'hAAAA);
      repeat (2) begin
         @(posedge CLK) short_m <= 8'h01;
         repeat (OVL - 3) @(posedge CLK);
         short_m <= 8'h00;
         repeat (3) @(posedge CLK);
      end
      tick(8);
      chk({drive, pf}, 16'hFF00);
      @(posedge CLK) short_m <= 8'h01;
      tick(OVL + 10);
      chk({drive, pf}, 16'hFE01);
      @(posedge CLK) short_m <= 8'h00;
      tick(10);
      chk({drive, pf}, 16'hFE01);
      rd(4'h1, 16'h0001);
      rd(4'hF, 16'h0000);
      wr(4'h0, 16'hAAA8);
      tick(6);
      chk({8'h00, pf}, 16'h0000);
      wr(4'h0, 16'hAAAE);
      @(posedge CLK) hot_m <= 8'h03;
      tick(8);
      chk({drive, pf}, 16'hFC03);
      @(posedge CLK) hot_m <= 8'h00;
      wr(4'h0, 16'hAAA0);
      tick(6);
      chk({8'h00, pf}, 16'h0000);
      wr(4'h0, 16'hFFE3);
      @(posedge CLK) open_m <= 8'h07;
      tick(OL - 2);
      chk({8'h00, ol}, 16'h0000);
      tick(10);
      chk({8'h00, ol}, 16'h0001);
      @(posedge CLK) open_m <= 8'h00;
      tick(5);
      chk({8'h00, ol}, 16'h0001);
      wr(4'h0, 16'h0000);
      din <= 8'h0F;
      tick(6);
      chk({8'h00, ol}, 16'h0000);
      @(posedge CLK) lhi_n <= 1'b0;
      repeat (LIMP_HOME_INPUT / 2) @(posedge CLK);
      lhi_n <= 1'b1;
      tick(8);
      chk({7'h00, limp, drive}, 16'h0000);
      @(posedge CLK) lhi_n <= 1'b0;
      tick(LIMP_HOME_INPUT + 8);
      chk({7'h00, limp, drive}, 16'h010F);
      rd(4'h2, 16'h010F);
      // clock enable low freezes limp-home and the gates
      @(posedge CLK) {ce, lhi_n} <= 2'b01;
      tick(10);
      chk({7'h00, limp, drive}, 16'h010F);
      @(posedge CLK) ce <= 1'b1;
      tick(10);
      chk({7'h00, limp, drive}, 16'h0000);
      give_verdict();
   end
endmodule : test_channel_fault_diagnosis
bind cfd_top cfd_checker #(.CHANNELS(CHANNELS), .OVL_CYC(OVL_CYC), .OL_CYC(OL_CYC)) chk_u (
   .CLK(CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .SENSE(SENSE), .DRIVE(DRIVE), .PROTECT_FAULT_FLAG(PROTECT_FAULT_FLAG),
   .OPEN_LOAD_FLAG(OPEN_LOAD_FLAG), .LIMP_HOME(LIMP_HOME));
